// *** core/pmc_pkg.sv ***
// shared constants and types for the privilege and mode controller
package pmc_pkg;

  // ----------------------------------------------------------------
  // reset values and control fields
  // ----------------------------------------------------------------
  localparam int          NEST_W    = 4;
  localparam logic [3:0]  NEST_MAX  = 4'hF;
  localparam logic [3:0]  NEST_ONE  = 4'h1;
  localparam logic [31:0] SP_RST    = 32'h0000_0000;
  localparam logic        USER_RST  = 1'b0;
  localparam logic        SPSEL_RST = 1'b0;
  localparam int          USER_BIT  = 0;
  localparam int          SPSEL_BIT = 1;

  // ----------------------------------------------------------------
  // instruction length decode: top five bits of the first halfword
  // ----------------------------------------------------------------
  localparam int          LEN_HI    = 15;
  localparam int          LEN_LO    = 11;
  localparam logic [4:0]  LEN32_MIN = 5'h1D;

  // ----------------------------------------------------------------
  // address map: top three bits pick a 512 MB region of the 4 GB space
  // ----------------------------------------------------------------
  localparam int          RGN_HI    = 31;
  localparam int          RGN_LO    = 29;
  localparam logic [2:0]  RGN_CODE  = 3'h0;
  localparam logic [2:0]  RGN_SRAM  = 3'h1;
  localparam logic [2:0]  RGN_PERI  = 3'h2;
  localparam logic [2:0]  RGN_XRAM0 = 3'h3;
  localparam logic [2:0]  RGN_XRAM1 = 3'h4;
  localparam logic [2:0]  RGN_SYS   = 3'h7;

  // ----------------------------------------------------------------
  // bit-band alias windows and the fields of an alias address
  // ----------------------------------------------------------------
  localparam int          BB_TAG_HI  = 31;
  localparam int          BB_TAG_LO  = 25;
  localparam logic [6:0]  BB_TAG_RAM = 7'h11;
  localparam logic [6:0]  BB_TAG_PER = 7'h21;
  localparam int          BB_BASE_LO = 28;
  localparam int          BB_OFS_HI  = 24;
  localparam int          BB_WORD_LO = 7;
  localparam int          BB_BIT_HI  = 6;
  localparam int          BB_BIT_LO  = 2;
  localparam logic [7:0]  BB_GAP     = 8'h00;

  // ----------------------------------------------------------------
  // states and fault causes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_PRIV_THREAD,
    PMC_USER_THREAD,
    PMC_PRIV_HANDLER
  } pmc_state_t;

  typedef enum logic [2:0] {
    PMC_FLT_NONE,
    PMC_FLT_ISET,
    PMC_FLT_INSTR,
    PMC_FLT_SREG,
    PMC_FLT_SYS
  } pmc_fault_t;

endpackage

// *** core/pmc_acc_if.sv ***
// access request and decode result between the controller and its address decoder
`timescale 1ns/10ps
interface pmc_acc_if;
  logic [31:0] addr;
  logic [1:0]  size;
  logic        fetch;
  logic        user;
  logic [2:0]  rgn;
  logic        deny;
  logic        bb_hit;
  logic [31:0] bb_addr;
  logic [4:0]  bb_bit;
  logic        split;
  logic        is_data;

  modport dec  (input addr, size, fetch, user,
                output rgn, deny, bb_hit, bb_addr, bb_bit, split, is_data);
  modport core (output addr, size, fetch, user,
                input rgn, deny, bb_hit, bb_addr, bb_bit, split, is_data);
endinterface

// *** core/pmc_addr_dec.sv ***
// address decoder: region, user denial, bit-band alias translation, word split
`timescale 1ns/10ps
module pmc_addr_dec (
  pmc_acc_if.dec acc
);

  // ----------------------------------------------------------------
  // region decode over the full 32-bit space
  // ----------------------------------------------------------------
  wire [6:0] bb_tag = acc.addr[pmc_pkg::BB_TAG_HI:pmc_pkg::BB_TAG_LO];
  wire [1:0] lane_mask = {acc.size[1], |acc.size};
  wire [2:0] last_lane = {1'b0, acc.addr[1:0]} + {1'b0, lane_mask};

  assign acc.rgn = acc.addr[pmc_pkg::RGN_HI:pmc_pkg::RGN_LO];
  // system space holds configuration and debug blocks, closed to user code
  assign acc.deny = acc.user && (acc.rgn == pmc_pkg::RGN_SYS);
  assign acc.is_data = (acc.rgn == pmc_pkg::RGN_SRAM) || (acc.rgn == pmc_pkg::RGN_XRAM0)
                    || (acc.rgn == pmc_pkg::RGN_XRAM1) || (acc.rgn == pmc_pkg::RGN_CODE);

  // ----------------------------------------------------------------
  // bit-band: one alias word per bit, mapped onto the owning word
  // ----------------------------------------------------------------
  assign acc.bb_hit = !acc.fetch
                   && ((bb_tag == pmc_pkg::BB_TAG_RAM) || (bb_tag == pmc_pkg::BB_TAG_PER));
  assign acc.bb_addr = {acc.addr[pmc_pkg::BB_TAG_HI:pmc_pkg::BB_BASE_LO], pmc_pkg::BB_GAP,
                        acc.addr[pmc_pkg::BB_OFS_HI:pmc_pkg::BB_WORD_LO], 2'h0};
  assign acc.bb_bit = acc.addr[pmc_pkg::BB_BIT_HI:pmc_pkg::BB_BIT_LO];

  // an access whose last byte lane passes lane 3 needs a second word beat
  assign acc.split = last_lane[2];

endmodule // pmc_addr_dec

// *** core/pmc_mode_ctrl.sv ***
// privilege level, thread/handler mode, stack selection and access checking
`timescale 1ns/10ps
module pmc_mode_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        exc_entry,
  input  wire logic        exc_return,
  input  wire logic        ctrl_wr,
  input  wire logic [1:0]  ctrl_wdata,
  input  wire logic        sp_wr,
  input  wire logic        sp_which,
  input  wire logic [31:0] sp_wdata,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_hw,
  input  wire logic        instr_restricted,
  input  wire logic        iset_clear,
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_addr,
  input  wire logic [1:0]  acc_size,
  input  wire logic        acc_fetch,
  output logic             priv_user,
  output logic             handler_mode,
  output logic             sp_process,
  output logic [31:0]      active_sp,
  output logic             instr_len32,
  output logic             fault,
  output logic [2:0]       fault_cause,
  output logic             ibus_req,
  output logic             dbus_req,
  output logic             sbus_req,
  output logic [31:0]      bus_addr,
  output logic             bb_op,
  output logic [4:0]       bb_bit,
  output logic             acc_split
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pmc_pkg::pmc_state_t state;
  pmc_pkg::pmc_state_t next_state;
  logic [3:0]          nest;
  logic                thr_user;
  logic                thr_spsel;
  logic [31:0]         main_stack_pointer;
  logic [31:0]         process_stack_pointer;

  pmc_acc_if acc ();

  pmc_addr_dec u_dec (
    .acc (acc.dec)
  );

  // ----------------------------------------------------------------
  // decode of the current level and mode
  // ----------------------------------------------------------------
  wire is_user    = (state == pmc_pkg::PMC_USER_THREAD);
  wire is_handler = (state == pmc_pkg::PMC_PRIV_HANDLER);

  assign acc.addr  = acc_addr;
  assign acc.size  = acc_size;
  assign acc.fetch = acc_fetch;
  assign acc.user  = is_user;

  // ----------------------------------------------------------------
  // fault detection, compact-set violation first
  // ----------------------------------------------------------------
  wire flt_iset  = iset_clear;
  wire flt_instr = is_user && instr_valid && instr_restricted;
  wire flt_sreg  = is_user && (ctrl_wr || sp_wr);
  wire flt_sys   = acc_valid && acc.deny;
  wire flt_any   = flt_iset || flt_instr || flt_sreg || flt_sys;

  wire pmc_pkg::pmc_fault_t next_cause =
      flt_iset  ? pmc_pkg::PMC_FLT_ISET  :
      flt_instr ? pmc_pkg::PMC_FLT_INSTR :
      flt_sreg  ? pmc_pkg::PMC_FLT_SREG  :
      flt_sys   ? pmc_pkg::PMC_FLT_SYS   : pmc_pkg::PMC_FLT_NONE;

  // ----------------------------------------------------------------
  // control and stack writes, privileged only
  // ----------------------------------------------------------------
  wire ctrl_ok = ctrl_wr && !is_user;
  wire sp_ok   = sp_wr && !is_user;

  wire next_thr_user = ctrl_ok ? ctrl_wdata[pmc_pkg::USER_BIT] : thr_user;
  // handler mode has no alternate stack, so the select bit is kept there
  wire next_thr_spsel = (ctrl_ok && !is_handler) ? ctrl_wdata[pmc_pkg::SPSEL_BIT] : thr_spsel;

  wire [31:0] sp_aligned = {sp_wdata[31:2], 2'h0};
  wire [31:0] next_main  = (sp_ok && !sp_which) ? sp_aligned : main_stack_pointer;
  wire [31:0] next_proc  = (sp_ok && sp_which) ? sp_aligned : process_stack_pointer;

  // ----------------------------------------------------------------
  // exception nesting; entry wins when entry and return coincide
  // ----------------------------------------------------------------
  wire nest_up   = exc_entry && (nest != pmc_pkg::NEST_MAX);
  wire nest_down = !exc_entry && exc_return && (nest != '0);
  wire [3:0] next_nest = nest_up   ? nest + pmc_pkg::NEST_ONE :
                         nest_down ? nest - pmc_pkg::NEST_ONE : nest;

  always_comb begin
    next_state = state;
    case (state)
      pmc_pkg::PMC_PRIV_HANDLER: begin
        if (next_nest == '0) begin
          next_state = next_thr_user ? pmc_pkg::PMC_USER_THREAD
                                     : pmc_pkg::PMC_PRIV_THREAD;
        end
      end
      default: begin
        if (exc_entry) begin
          next_state = pmc_pkg::PMC_PRIV_HANDLER;
        end else if (ctrl_ok) begin
          next_state = next_thr_user ? pmc_pkg::PMC_USER_THREAD
                                     : pmc_pkg::PMC_PRIV_THREAD;
        end
      end
    endcase
  end

  wire next_hdl      = (next_state == pmc_pkg::PMC_PRIV_HANDLER);
  wire next_use_proc = !next_hdl && next_thr_spsel;

  // ----------------------------------------------------------------
  // instruction length and bus routing
  // ----------------------------------------------------------------
  wire [4:0] hw_top   = instr_hw[pmc_pkg::LEN_HI:pmc_pkg::LEN_LO];
  wire       is_len32 = (hw_top >= pmc_pkg::LEN32_MIN);
  wire       acc_go   = acc_valid && !acc.deny;
  wire       go_ibus  = acc_go && acc_fetch;
  wire       go_dbus  = acc_go && !acc_fetch && acc.is_data;
  wire       go_sbus  = acc_go && !acc_fetch && !acc.is_data;
  wire       go_bb    = acc_go && acc.bb_hit;
  wire [31:0] next_bus_addr = acc.bb_hit ? acc.bb_addr : acc_addr;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= pmc_pkg::PMC_PRIV_THREAD;
      nest  <= '0;
      thr_user  <= pmc_pkg::USER_RST;
      thr_spsel <= pmc_pkg::SPSEL_RST;
      main_stack_pointer    <= pmc_pkg::SP_RST;
      process_stack_pointer <= pmc_pkg::SP_RST;
    end else begin
      state <= next_state;
      nest  <= next_nest;
      thr_user  <= next_thr_user;
      thr_spsel <= next_thr_spsel;
      main_stack_pointer    <= next_main;
      process_stack_pointer <= next_proc;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      priv_user    <= 1'b0;
      handler_mode <= 1'b0;
      sp_process   <= 1'b0;
      active_sp    <= pmc_pkg::SP_RST;
    end else begin
      priv_user    <= (next_state == pmc_pkg::PMC_USER_THREAD);
      handler_mode <= next_hdl;
      sp_process   <= next_use_proc;
      active_sp    <= next_use_proc ? next_proc : next_main;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      instr_len32 <= 1'b0;
      fault       <= 1'b0;
      fault_cause <= pmc_pkg::PMC_FLT_NONE;
    end else begin
      instr_len32 <= instr_valid && is_len32;
      fault       <= flt_any;
      fault_cause <= next_cause;
    end
  end

  // separate request lines route each access to its own bus; with one access per cycle, fetch and data never overlap
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ibus_req  <= 1'b0;
      dbus_req  <= 1'b0;
      sbus_req  <= 1'b0;
      bus_addr  <= '0;
      bb_op     <= 1'b0;
      bb_bit    <= '0;
      acc_split <= 1'b0;
    end else begin
      ibus_req  <= go_ibus;
      dbus_req  <= go_dbus;
      sbus_req  <= go_sbus;
      bus_addr  <= next_bus_addr;
      bb_op     <= go_bb;
      bb_bit    <= acc.bb_bit;
      acc_split <= acc_go && acc.split && !acc.bb_hit;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  wire [4:0] acc_bit_idx = acc_addr[pmc_pkg::BB_BIT_HI:pmc_pkg::BB_BIT_LO];

  mode_combo_a: assert property (!(priv_user && handler_mode))
    else $error("user level seen in handler mode");

  user_block_a: assert property (flt_instr && !iset_clear
                                 |=> fault && fault_cause == pmc_pkg::PMC_FLT_INSTR)
    else $error("restricted instruction at user level did not fault");

  priv_allow_a: assert property (!is_user && !iset_clear |=> !fault)
    else $error("fault raised at privileged level");

  entry_handler_a: assert property (exc_entry |=> handler_mode && !priv_user)
    else $error("exception entry did not reach privileged handler");

  return_restore_a: assert property (is_handler && nest == pmc_pkg::NEST_ONE && exc_return
                                     && !exc_entry && !ctrl_wr
                                     |=> !handler_mode && priv_user == $past(thr_user))
    else $error("exception return did not restore thread level");

  len_decode_a: assert property (instr_valid |=> instr_len32 == ($past(hw_top) >= 5'h1D))
    else $error("instruction length decode wrong");

  iset_fault_a: assert property (iset_clear |=> fault && fault_cause == pmc_pkg::PMC_FLT_ISET)
    else $error("leaving the compact set did not fault");

  stack_sel_a: assert property (handler_mode |-> !sp_process && active_sp == main_stack_pointer)
    else $error("handler not on main stack");

  bb_map_a: assert property (go_bb |=> bb_op && bus_addr[1:0] == 2'h0
                             && bb_bit == $past(acc_bit_idx))
    else $error("bit-band translation wrong");

  sys_deny_a: assert property (is_user && acc_valid && acc.rgn == pmc_pkg::RGN_SYS
                               |=> fault && !ibus_req && !dbus_req && !sbus_req)
    else $error("user access to system space not refused");

  // at most one request line per cycle: each allowed access is routed to exactly one bus, a denied one to none
  bus_onehot_a: assert property ($onehot0({ibus_req, dbus_req, sbus_req}))
    else $error("more than one bus request at once");

  bus_sep_a: assert property (go_ibus |=> ibus_req)
    else $error("bus routing wrong");

  data_route_a: assert property (go_dbus |=> dbus_req && !sbus_req)
    else $error("data access not on data bus");

endmodule // pmc_mode_ctrl

// *** sim/pmc_bench.sv ***
// self-checking bench for the privilege and mode controller
`timescale 1ns/10ps
module pmc_bench;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic        ref_clk, rstn, exc_entry, exc_return, ctrl_wr, sp_wr, sp_which;
  logic [1:0]  ctrl_wdata, acc_size;
  logic [31:0] sp_wdata, acc_addr, seed, ms, ps, r, a2;
  logic        instr_valid, instr_restricted, iset_clear, acc_valid, acc_fetch;
  logic [15:0] instr_hw;
  logic        priv_user, handler_mode, sp_process, instr_len32, fault;
  logic        ibus_req, dbus_req, sbus_req, bb_op, acc_split;
  logic [31:0] active_sp, bus_addr;
  logic [2:0]  fault_cause;
  logic [4:0]  bb_bit;
  logic [46:0] obs;
  logic [46:0] exp_q[$];
  logic [46:0] msk_q[$];
  int          miscompares, compares, cycles;

  pmc_mode_ctrl uut (
    .ref_clk(ref_clk), .rstn(rstn), .exc_entry(exc_entry), .exc_return(exc_return),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .sp_wr(sp_wr), .sp_which(sp_which),
    .sp_wdata(sp_wdata), .instr_valid(instr_valid), .instr_hw(instr_hw),
    .instr_restricted(instr_restricted), .iset_clear(iset_clear), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_size(acc_size), .acc_fetch(acc_fetch),
    .priv_user(priv_user), .handler_mode(handler_mode), .sp_process(sp_process),
    .active_sp(active_sp), .instr_len32(instr_len32), .fault(fault),
    .fault_cause(fault_cause), .ibus_req(ibus_req), .dbus_req(dbus_req),
    .sbus_req(sbus_req), .bus_addr(bus_addr), .bb_op(bb_op), .bb_bit(bb_bit),
    .acc_split(acc_split)
  );

  assign obs = {fault, fault_cause, ibus_req, dbus_req, sbus_req, bb_op, bb_bit,
                acc_split, instr_len32, bus_addr};

  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(logic [46:0] seen, logic [46:0] expv);
    compares++;
    if (seen !== expv) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic finish_test();
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("Error at %0t: %0d expected results never appeared", $time, exp_q.size());
    end
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  // one note per expected output event; a denied access carries no bus fields
  task automatic expect_ev(logic av, logic [31:0] a, logic [1:0] sz, logic f, logic len,
                           logic [2:0] fc);
    logic        ok, bb, db, sp;
    logic [31:0] ba;
    logic [46:0] e, m;
    ok = av && fc == 3'h0;
    bb = ok && !f && (a[31:25] == 7'h11 || a[31:25] == 7'h21);
    ba = bb ? {a[31:28], 8'h00, a[24:7], 2'b00} : a;
    sp = ok && !bb && ({1'b0, a[1:0]} + (3'h1 << sz) > 3'h4);
    db = !f && a[31:29] inside {3'h0, 3'h1, 3'h3, 3'h4};
    e = {fc != 3'h0, fc, ok && f, ok && db, ok && !f && !db, bb, bb ? a[6:2] : 5'h00,
         sp, len, ok ? ba : 32'h0};
    m = {1'b1, 3'h7, 4'hF, bb ? 5'h1F : 5'h00, 1'b1, 1'b1, ok ? 32'hFFFF_FFFF : 32'h0};
    if (fc != 3'h0 || ok || len) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
  endtask

  task automatic lvl(logic u, logic h, logic p, logic [31:0] sp);
    check({12'h000, priv_user, handler_mode, sp_process, active_sp}, {12'h000, u, h, p, sp});
  endtask

  task automatic instr(logic [15:0] hw, logic rs, logic [2:0] fc);
    instr_valid = 1'b1; instr_hw = hw; instr_restricted = rs;
    expect_ev(1'b0, 32'h0, 2'h0, 1'b0, hw[15:11] >= 5'h1D, fc);
    tick(); instr_valid = 1'b0;
  endtask

  task automatic acc(logic [31:0] a, logic [1:0] sz, logic f, logic [2:0] fc);
    acc_valid = 1'b1; acc_addr = a; acc_size = sz; acc_fetch = f;
    expect_ev(1'b1, a, sz, f, 1'b0, fc);
    tick(); acc_valid = 1'b0;
  endtask

  task automatic ctrl(logic [1:0] v, logic [2:0] fc);
    ctrl_wr = 1'b1; ctrl_wdata = v;
    expect_ev(1'b0, 32'h0, 2'h0, 1'b0, 1'b0, fc);
    tick(); ctrl_wr = 1'b0;
  endtask

  task automatic spw(logic w, logic [31:0] v, logic [2:0] fc);
    sp_wr = 1'b1; sp_which = w; sp_wdata = v;
    expect_ev(1'b0, 32'h0, 2'h0, 1'b0, 1'b0, fc);
    tick(); sp_wr = 1'b0;
  endtask

  task automatic exc(logic e, logic rt);
    exc_entry = e; exc_return = rt;
    tick(); exc_entry = 1'b0; exc_return = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // result watcher and timeout
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (rstn && (fault | ibus_req | dbus_req | sbus_req | instr_len32) !== 1'b0) begin
      if (exp_q.size() == 0) check(obs, 47'h0);
      else check(obs & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 2000) begin
      miscompares++;
      $display("Error at %0t: run did not finish in time", $time);
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0; rstn = 1'b0; exc_entry = 1'b0; exc_return = 1'b0; ctrl_wr = 1'b0;
    ctrl_wdata = 2'h0; sp_wr = 1'b0; sp_which = 1'b0; sp_wdata = 32'h0;
    instr_valid = 1'b0; instr_hw = 16'h0000; instr_restricted = 1'b0; iset_clear = 1'b0;
    acc_valid = 1'b0; acc_addr = 32'h0; acc_size = 2'h0; acc_fetch = 1'b0;
    seed = 32'h0001_348F;
    repeat (3) @(posedge ref_clk);
    #1 rstn = 1'b1;
    lvl(1'b0, 1'b0, 1'b0, 32'h0);
    ms = xorshift(); ps = xorshift();
    spw(1'b0, ms, 3'h0); ms[1:0] = 2'b00;
    lvl(1'b0, 1'b0, 1'b0, ms);
    spw(1'b1, ps, 3'h0); ps[1:0] = 2'b00;
    lvl(1'b0, 1'b0, 1'b0, ms);
    ctrl(2'b10, 3'h0);
    lvl(1'b0, 1'b0, 1'b1, ps);
    ctrl(2'b11, 3'h0);
    lvl(1'b1, 1'b0, 1'b1, ps);
    // user level: blocked operations fault and change nothing
    r = xorshift();
    instr(r[15:0], 1'b1, 3'h2);
    instr(16'hE800, 1'b0, 3'h0);
    instr(16'hE7FF, 1'b0, 3'h0);
    iset_clear = 1'b1;
    expect_ev(1'b0, 32'h0, 2'h0, 1'b0, 1'b0, 3'h1);
    tick(); iset_clear = 1'b0;
    ctrl(2'b00, 3'h3);
    spw(1'b1, 32'h0, 3'h3);
    lvl(1'b1, 1'b0, 1'b1, ps);
    acc(32'hE000_ED00, 2'h2, 1'b0, 3'h4);
    acc(32'h4000_0001, 2'h0, 1'b0, 3'h0);
    // exception entry, nesting, return
    exc(1'b1, 1'b0);
    lvl(1'b0, 1'b1, 1'b0, ms);
    instr(16'hF000, 1'b1, 3'h0);
    acc(32'hE000_0000, 2'h2, 1'b0, 3'h0);
    ctrl(2'b11, 3'h0);
    lvl(1'b0, 1'b1, 1'b0, ms);
    exc(1'b1, 1'b0);
    exc(1'b0, 1'b1);
    lvl(1'b0, 1'b1, 1'b0, ms);
    exc(1'b0, 1'b1);
    lvl(1'b1, 1'b0, 1'b1, ps);
    exc(1'b0, 1'b1);
    lvl(1'b1, 1'b0, 1'b1, ps);
    exc(1'b1, 1'b1);
    lvl(1'b0, 1'b1, 1'b0, ms);
    // privileged accesses: bit-band, unaligned, fetch
    acc(32'h2200_0084, 2'h2, 1'b0, 3'h0);
    acc(32'h4220_0010, 2'h0, 1'b0, 3'h0);
    acc(32'h2000_0003, 2'h1, 1'b0, 3'h0);
    acc(32'h0000_0100, 2'h2, 1'b1, 3'h0);
    // back-to-back random traffic, no faults allowed at privileged level
    for (int i = 0; i < 64; i++) begin
      r = xorshift();
      a2 = xorshift();
      instr_valid = 1'b1; instr_hw = r[15:0]; instr_restricted = r[19];
      acc_valid = 1'b1; acc_fetch = r[16];
      acc_size = r[16] ? 2'h2 : 2'(r[18:17] % 2'h3);
      acc_addr = r[16] ? {3'h0, a2[28:2], 2'b00} : a2;
      expect_ev(1'b1, acc_addr, acc_size, r[16], r[15:11] >= 5'h1D, 3'h0);
      tick();
    end
    instr_valid = 1'b0; acc_valid = 1'b0;
    tick();
    exc(1'b0, 1'b1);
    lvl(1'b1, 1'b0, 1'b1, ps);
    tick();
    finish_test();
  end
endmodule // pmc_bench
